/* shared/irq_seq_pkg.sv */
// Constants and types for the interrupt entry and exit sequencer
package irq_seq_pkg;
   localparam int          NSRC        = 8;
   localparam int          GIE_BIT     = 7;
   localparam int          VSEL_BIT    = 0;
   // Program memory layout, in instruction words
   localparam logic [12:0] APP_BASE    = 13'h0000;
   localparam logic [12:0] BOOT_BASE   = 13'h1c00;
   localparam logic [12:0] VEC_STRIDE  = 13'h0002;
   // Sequence lengths in core clock cycles, then the stack step in bytes
   localparam logic [2:0]  ENTRY_CYC   = 3'h4;
   localparam logic [2:0]  WAKE_CYC    = 3'h4;
   localparam logic [2:0]  JUMP_CYC    = 3'h3;
   localparam logic [2:0]  RETURN_CYC  = 3'h4;
   localparam logic [15:0] SP_STEP     = 16'h0002;
   // Register byte offsets
   localparam logic [7:0]  ADDR_STATUS = 8'h00;
   localparam logic [7:0]  ADDR_GICTRL = 8'h04;
   localparam logic [7:0]  ADDR_ENABLE = 8'h08;
   localparam logic [7:0]  ADDR_FLAGS  = 8'h0c;
   localparam logic [7:0]  ADDR_LEVEL  = 8'h10;
   localparam logic [7:0]  ADDR_SP     = 8'h14;
   localparam logic [7:0]  ADDR_SEQ    = 8'h18;
   // Reset values
   localparam logic [7:0]  STATUS_RST  = 8'h00;
   localparam logic [7:0]  BYTE_RST    = 8'h00;
   localparam logic [15:0] SP_RST      = 16'h0000;
   typedef enum logic [2:0] {
      ST_RUN    = 3'b000,
      ST_WAKE   = 3'b001,
      ST_ENTRY  = 3'b010,
      ST_JUMP   = 3'b011,
      ST_RETURN = 3'b100
   } seq_state_t;
endpackage

/* verilog/irq_sequencer.sv */
// Interrupt entry, return and wake sequencer with APB registers
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module irq_sequencer (
   input  wire logic        pclk,          // Core clock
   input  wire logic        presetn,       // Async reset, low
   input  wire logic [7:0]  paddr,         // APB address
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic [7:0]  src_event,     // Flag-type events
   input  wire logic [7:0]  src_cond,      // Level-type conditions
   input  wire logic        instr_done,    // Instruction completed
   input  wire logic        instr_sei,     // Global enable instr
   input  wire logic        instr_cli,     // Global disable instr
   input  wire logic        instr_return_from_interrupt_instr,    // Return instr begins
   input  wire logic        sleeping,      // Core asleep
   input  wire logic        wake_ready,    // Start-up time over
   input  wire logic [12:0] pc_now,        // Current PC
   input  wire logic        boot_reset_fuse,           // Fuse
   input  wire logic        app_boot_lock_setting,     // Lock
   input  wire logic        boot_section_lock_setting, // Lock
   output logic             core_hold,     // Stall the core
   output logic             pc_push,       // Push PC pulse
   output logic             pc_pop,        // Pop PC pulse
   output logic             vector_go,     // Fetch vector pulse
   output logic      [12:0] vector_addr,   // Vector word address
   output logic             handler_start, // Handler reached
   output logic      [12:0] reset_vector,  // Reset vector
   output logic      [15:0] stack_pointer, // Stack pointer
   output logic             global_enable  // Global enable
);
   irq_seq_pkg::seq_state_t state_reg;
   logic [2:0]  cnt_reg;
   logic [7:0]  status_reg;
   logic [7:0]  status_next;
   logic [7:0]  gictrl_reg;
   logic [7:0]  enable_reg;
   logic [7:0]  flags_reg;
   logic [7:0]  flags_next;
   logic [7:0]  level_reg;
   logic [15:0] sp_reg;
   logic [2:0]  idx_reg;
   logic [12:0] vaddr_reg;
   logic [12:0] rstvec_reg;
   logic        guard_reg;
   logic        hold_reg;
   logic        push_reg;
   logic        pop_reg;
   logic        go_reg;
   logic        hstart_reg;
   logic        pready_reg;
   logic        perr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata;
   logic        rerr;
   logic        acc_done;
   logic        wr_en;
   logic [7:0]  req;
   logic        gie;
   logic        in_boot;
   logic        suppress;
   logic        can_irq;
   logic [2:0]  pick;
   logic [12:0] vbase;
   logic        run_take;
   logic        wake_take;
   logic        start_entry;
   logic        start_return;
   logic        ret_end;

   // Lowest set bit of a request vector
   function automatic logic [2:0] lowest(input logic [7:0] r);
      logic [2:0] i;
      i = 3'h0;
      for (int k = irq_seq_pkg::NSRC - 1; k >= 0; k--) begin
         if (r[k]) begin
            i = k[2:0];
         end
      end
      return i;
   endfunction

   // Request gathering and eligibility
   assign gie = status_reg[irq_seq_pkg::GIE_BIT];
   // Flags hold latched requests, level sources pass live
   assign req = ((flags_reg & ~level_reg) |
                 (src_cond & level_reg)) & enable_reg;
   assign in_boot = pc_now >= irq_seq_pkg::BOOT_BASE;
   assign suppress =
      (app_boot_lock_setting & ~in_boot & gictrl_reg[0]) |
      (boot_section_lock_setting & in_boot & ~gictrl_reg[0]);
   assign can_irq = gie & (|req) & ~suppress;
   assign pick = lowest(req);
   assign vbase = gictrl_reg[irq_seq_pkg::VSEL_BIT]
                  ? irq_seq_pkg::BOOT_BASE
                  : irq_seq_pkg::APP_BASE;

   // Run take only at a boundary, never beside enable or disable; wake take never beside disable
   assign run_take = (state_reg == irq_seq_pkg::ST_RUN) &&
                     instr_done && !instr_cli && !instr_sei &&
                     !instr_return_from_interrupt_instr && can_irq;
   assign wake_take = (state_reg == irq_seq_pkg::ST_WAKE) &&
                      wake_ready && can_irq && !instr_cli &&
                      (cnt_reg == irq_seq_pkg::WAKE_CYC - 3'h1);
   assign start_entry = run_take | wake_take;
   assign start_return = (state_reg == irq_seq_pkg::ST_RUN) &&
                         instr_return_from_interrupt_instr;
   assign ret_end = (state_reg == irq_seq_pkg::ST_RETURN) &&
                    (cnt_reg == irq_seq_pkg::RETURN_CYC - 3'h1);

   // Sequencer runs directly on pclk with no divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= irq_seq_pkg::ST_RUN;
         cnt_reg   <= 3'h0;
      end else begin
         case (state_reg)
            irq_seq_pkg::ST_RUN: begin
               cnt_reg <= 3'h0;
               if (start_return) begin
                  state_reg <= irq_seq_pkg::ST_RETURN;
               end else if (run_take) begin
                  state_reg <= irq_seq_pkg::ST_ENTRY;
               end else if (sleeping && can_irq && !guard_reg) begin
                  state_reg <= irq_seq_pkg::ST_WAKE;
               end
            end
            irq_seq_pkg::ST_WAKE: begin
               if (!can_irq) begin
                  state_reg <= irq_seq_pkg::ST_RUN;
                  cnt_reg   <= 3'h0;
               end else if (wake_take) begin
                  state_reg <= irq_seq_pkg::ST_ENTRY;
                  cnt_reg   <= 3'h0;
               end else if (wake_ready) begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            irq_seq_pkg::ST_ENTRY: begin
               if (cnt_reg == irq_seq_pkg::ENTRY_CYC - 3'h1) begin
                  state_reg <= irq_seq_pkg::ST_JUMP;
                  cnt_reg   <= 3'h0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            irq_seq_pkg::ST_JUMP: begin
               if (cnt_reg == irq_seq_pkg::JUMP_CYC - 3'h1) begin
                  state_reg <= irq_seq_pkg::ST_RUN;
                  cnt_reg   <= 3'h0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            irq_seq_pkg::ST_RETURN: begin
               if (ret_end) begin
                  state_reg <= irq_seq_pkg::ST_RUN;
                  cnt_reg   <= 3'h0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            default: begin
               state_reg <= irq_seq_pkg::ST_RUN;
               cnt_reg   <= 3'h0;
            end
         endcase
      end
   end

   // Strobes to the core: push, vector fetch, handler, pop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg   <= 1'b0;
         push_reg   <= 1'b0;
         pop_reg    <= 1'b0;
         go_reg     <= 1'b0;
         hstart_reg <= 1'b0;
      end else begin
         hold_reg <= start_entry || start_return ||
                     ((state_reg != irq_seq_pkg::ST_RUN) &&
                      (state_reg != irq_seq_pkg::ST_WAKE) &&
                      !ret_end && !(hstart_go()));
         push_reg <= start_entry;
         pop_reg  <= start_return;
         go_reg   <= (state_reg == irq_seq_pkg::ST_ENTRY) &&
                     (cnt_reg == irq_seq_pkg::ENTRY_CYC - 3'h1);
         hstart_reg <= hstart_go();
      end
   end

   // Last jump cycle reaches the handler
   function automatic logic hstart_go();
      return (state_reg == irq_seq_pkg::ST_JUMP) &&
             (cnt_reg == irq_seq_pkg::JUMP_CYC - 3'h1);
   endfunction

   // Latch the winner and form its vector address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_reg   <= 3'h0;
         vaddr_reg <= 13'h0000;
      end else if (start_entry) begin
         idx_reg   <= pick;
         // Slot 0 belongs to reset, sources follow
         vaddr_reg <= vbase + 13'({10'h000, pick} + 13'h0001) *
                      irq_seq_pkg::VEC_STRIDE;
      end
   end

   // Reset vector follows the fuse on every clock after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rstvec_reg <= 13'h0000;
      end else begin
         rstvec_reg <= boot_reset_fuse ? irq_seq_pkg::BOOT_BASE
                                       : irq_seq_pkg::APP_BASE;
      end
   end

   // One instruction must finish after return or enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         guard_reg <= 1'b0;
      end else if (ret_end || instr_sei) begin
         guard_reg <= 1'b1;
      end else if (instr_done) begin
         guard_reg <= 1'b0;
      end
   end

   // Bus write strobe on the ready edge
   assign acc_done = psel && penable && pready_reg;
   assign wr_en = acc_done && pwrite;

   // Status flags; not saved on entry, handlers keep them
   always_comb begin
      status_next = status_reg;
      if (wr_en && paddr == irq_seq_pkg::ADDR_STATUS) begin
         status_next = pwdata[7:0];
      end
      if (start_entry || instr_cli) begin
         status_next[irq_seq_pkg::GIE_BIT] = 1'b0;
      end else if (ret_end || instr_sei) begin
         status_next[irq_seq_pkg::GIE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= irq_seq_pkg::STATUS_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   // Flags: write one clears, entry clears, new event wins
   always_comb begin
      flags_next = flags_reg;
      if (wr_en && paddr == irq_seq_pkg::ADDR_FLAGS) begin
         flags_next = flags_next & ~pwdata[7:0];
      end
      if (start_entry && !level_reg[pick]) begin
         flags_next[pick] = 1'b0;
      end
      flags_next = flags_next | (src_event & ~level_reg);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= irq_seq_pkg::BYTE_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Stack pointer: two bytes down on entry, up on return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg <= irq_seq_pkg::SP_RST;
      end else if (start_entry) begin
         sp_reg <= sp_reg - irq_seq_pkg::SP_STEP;
      end else if (start_return) begin
         sp_reg <= sp_reg + irq_seq_pkg::SP_STEP;
      end else if (wr_en && paddr == irq_seq_pkg::ADDR_SP) begin
         sp_reg <= pwdata[15:0];
      end
   end

   // Plain control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gictrl_reg <= irq_seq_pkg::BYTE_RST;
         enable_reg <= irq_seq_pkg::BYTE_RST;
         level_reg  <= irq_seq_pkg::BYTE_RST;
      end else if (wr_en) begin
         if (paddr == irq_seq_pkg::ADDR_GICTRL) begin
            gictrl_reg <= {7'h00, pwdata[0]};
         end else if (paddr == irq_seq_pkg::ADDR_ENABLE) begin
            enable_reg <= pwdata[7:0];
         end else if (paddr == irq_seq_pkg::ADDR_LEVEL) begin
            level_reg <= pwdata[7:0];
         end
      end
   end

   // Read decode
   always_comb begin
      rdata = 32'h0000_0000;
      rerr  = 1'b0;
      if (paddr == irq_seq_pkg::ADDR_STATUS) begin
         rdata[7:0] = status_reg;
      end else if (paddr == irq_seq_pkg::ADDR_GICTRL) begin
         rdata[7:0] = gictrl_reg;
      end else if (paddr == irq_seq_pkg::ADDR_ENABLE) begin
         rdata[7:0] = enable_reg;
      end else if (paddr == irq_seq_pkg::ADDR_FLAGS) begin
         rdata[7:0] = flags_reg;
      end else if (paddr == irq_seq_pkg::ADDR_LEVEL) begin
         rdata[7:0] = level_reg;
      end else if (paddr == irq_seq_pkg::ADDR_SP) begin
         rdata[15:0] = sp_reg;
      end else if (paddr == irq_seq_pkg::ADDR_SEQ) begin
         rdata[20:0] = {rstvec_reg, guard_reg, idx_reg,
                        1'b0, state_reg};
      end else begin
         rerr = 1'b1;
      end
   end

   // One wait state, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         perr_reg   <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= psel && penable && !pready_reg;
         if (psel && penable && !pready_reg) begin
            perr_reg   <= rerr;
            prdata_reg <= pwrite ? 32'h0000_0000 : rdata;
         end else begin
            perr_reg <= 1'b0;
         end
      end
   end

   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = perr_reg;
   assign core_hold     = hold_reg;
   assign pc_push       = push_reg;
   assign pc_pop        = pop_reg;
   assign vector_go     = go_reg;
   assign vector_addr   = vaddr_reg;
   assign handler_start = hstart_reg;
   assign reset_vector  = rstvec_reg;
   assign stack_pointer = sp_reg;
   assign global_enable = gie;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_entry_gie;
      start_entry |=> !gie;
   endproperty
   a_entry_gie: assert property (p_entry_gie)
      else $error("global enable left set on entry");

   property p_entry_len;
      run_take |-> ##5 vector_go ##3 handler_start;
   endproperty
   a_entry_len: assert property (p_entry_len)
      else $error("entry or jump length wrong");

   property p_jump;
      vector_go |-> !handler_start [*3] ##1 handler_start;
   endproperty
   a_jump: assert property (p_jump)
      else $error("vector jump not three cycles");

   property p_sp_down;
      start_entry |=> stack_pointer == $past(sp_reg) - 16'h0002;
   endproperty
   a_sp_down: assert property (p_sp_down)
      else $error("stack pointer not lowered by two");

   property p_return;
      start_return |=> !gie [*4] ##1 (gie && global_enable);
   endproperty
   a_return: assert property (p_return)
      else $error("return not four cycles");

   property p_no_take_cli;
      instr_cli |-> !start_entry;
   endproperty
   a_no_take_cli: assert property (p_no_take_cli)
      else $error("interrupt taken beside disable");

   property p_after_ret;
      ret_end |=> !start_entry;
   endproperty
   a_after_ret: assert property (p_after_ret)
      else $error("interrupt taken with no instruction");

   property p_enabled;
      start_entry |-> gie && enable_reg[pick] &&
                      ((req & ((8'h01 << pick) - 8'h01)) == 8'h00);
   endproperty
   a_enabled: assert property (p_enabled)
      else $error("disabled or lower priority taken");

   property p_flag_clr;
      start_entry && !level_reg[pick] && !src_event[pick] |=>
         !flags_reg[idx_reg];
   endproperty
   a_flag_clr: assert property (p_flag_clr)
      else $error("flag not cleared on entry");

   property p_wake;
      state_reg == irq_seq_pkg::ST_ENTRY &&
      $past(state_reg) == irq_seq_pkg::ST_WAKE |->
         $past(wake_ready, 4) && $past(wake_ready);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake entry too short");
endmodule
`default_nettype wire

/* test/core_model.sv */
// Behavioural core: two-cycle instructions that stall on core_hold
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic        pclk,       // Core clock
   input  wire logic        presetn,    // Async reset, low
   input  wire logic        core_hold,  // Stall from sequencer
   input  wire logic        run,        // Keep fetching
   input  wire logic [1:0]  op,         // 0 plain 1 sei 2 cli 3 return_from_interrupt_instr
   output logic             instr_done, // Instruction completed
   output logic             instr_sei,  // Enable instr
   output logic             instr_cli,  // Disable instr
   output logic             instr_return_from_interrupt_instr, // Return instr starts
   output logic      [12:0] pc_now      // Program counter
);
   logic busy_reg;
   // Completion waits out any stall, so no done while held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg   <= 1'b0;
         instr_done <= 1'b0;
         instr_sei  <= 1'b0;
         instr_cli  <= 1'b0;
         instr_return_from_interrupt_instr <= 1'b0;
         pc_now     <= 13'h0000;
      end else begin
         instr_done <= 1'b0;
         instr_sei  <= 1'b0;
         instr_cli  <= 1'b0;
         instr_return_from_interrupt_instr <= 1'b0;
         if (busy_reg && !core_hold) begin
            busy_reg   <= 1'b0;
            instr_done <= (op != 2'h3);
            instr_sei  <= (op == 2'h1);
            instr_cli  <= (op == 2'h2);
            instr_return_from_interrupt_instr <= (op == 2'h3);
            pc_now     <= pc_now + 13'h0001;
         end else if (run && !core_hold) begin
            busy_reg <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* test/irq_sequencer_tb.sv */
// Self-checking bench for the interrupt entry and exit sequencer
`timescale 1ns/1ps
`default_nettype none
module irq_sequencer_tb;
   localparam logic [15:0] SP0 = 16'h0460;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, sleeping = 1'b0, wake_ready = 1'b0;
   logic        fuse = 1'b0, app_lock = 1'b0, boot_lock = 1'b0, run = 1'b0;
   logic [7:0]  paddr = 8'h00, src_event = 8'h00, src_cond = 8'h00, ev;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0]  op = 2'h0;
   logic        pready, pslverr, instr_done, instr_sei, instr_cli, instr_return_from_interrupt_instr;
   logic        core_hold, pc_push, pc_pop, vector_go, handler_start, gie;
   logic [12:0] pc_now, vector_addr, reset_vector;
   logic [15:0] stack_pointer;
   logic [32:0] exp_q[$];
   int          error_cnt = 0, check_count = 0, done_total = 0, push_total = 0;
   int          c, cp, dn, mark = 0, p0;

   irq_sequencer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_event(src_event), .src_cond(src_cond), .instr_done(instr_done),
      .instr_sei(instr_sei), .instr_cli(instr_cli), .instr_return_from_interrupt_instr(instr_return_from_interrupt_instr),
      .sleeping(sleeping), .wake_ready(wake_ready), .pc_now(pc_now),
      .boot_reset_fuse(fuse), .app_boot_lock_setting(app_lock),
      .boot_section_lock_setting(boot_lock), .core_hold(core_hold),
      .pc_push(pc_push), .pc_pop(pc_pop), .vector_go(vector_go),
      .vector_addr(vector_addr), .handler_start(handler_start),
      .reset_vector(reset_vector), .stack_pointer(stack_pointer),
      .global_enable(gie));
   core_model u_core (.pclk(pclk), .presetn(presetn), .core_hold(core_hold),
      .run(run), .op(op), .instr_done(instr_done), .instr_sei(instr_sei),
      .instr_cli(instr_cli), .instr_return_from_interrupt_instr(instr_return_from_interrupt_instr), .pc_now(pc_now));

   // Clock
   always #10 pclk = ~pclk;

   task automatic check(input string nm, input logic [32:0] s, e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp(input string nm, input logic [32:0] s);
      if (exp_q.size() == 0) begin
         error_cnt++;
         $display("[FAIL] %s expected none seen %h", nm, s);
      end else begin
         check(nm, s, exp_q.pop_front());
      end
   endtask
   // Result monitor and tallies
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
         cmp("read", {pslverr, prdata});
      if (vector_go === 1'b1) cmp("vector", 33'(vector_addr));
      if (instr_done === 1'b1) done_total <= done_total + 1;
      if (pc_push === 1'b1) push_total <= push_total + 1;
   end
   function automatic logic sig(input int w);
      case (w)
         0: return pc_push;
         1: return vector_go;
         2: return handler_start;
         3: return pc_pop;
         4: return gie;
         5: return instr_sei;
         6: return instr_cli;
         default: return instr_return_from_interrupt_instr;
      endcase
   endfunction
   function automatic logic [32:0] vec(input logic [12:0] b, input int i);
      return 33'(b + irq_seq_pkg::VEC_STRIDE * 13'(i + 1));
   endfunction
   task automatic wait_sig(input int w, output int n);
      n = 0;
      while (sig(w) !== 1'b1 && n < 80) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 80) error_cnt++;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) error_cnt++;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic pulse(input logic [7:0] m);
      src_event <= m;
      @(posedge pclk);
      src_event <= 8'h00;
   endtask
   task automatic do_op(input logic [1:0] o);
      op <= o;
      wait_sig(4 + int'(o), c);
      op <= 2'h0;
   endtask
   task automatic entry();
      wait_sig(0, cp);
      dn = done_total - mark;
      check("enable", 33'(gie), 33'h0);
      check("sp", 33'(stack_pointer), 33'(SP0 - irq_seq_pkg::SP_STEP));
      wait_sig(1, c);
      check("entry", 33'(c), 33'(irq_seq_pkg::ENTRY_CYC));
      wait_sig(2, c);
      check("jump", 33'(c), 33'(irq_seq_pkg::JUMP_CYC));
   endtask
   task automatic leave();
      do_op(2'h3);
      wait_sig(3, c);
      check("sp", 33'(stack_pointer), 33'(SP0));
      wait_sig(4, c);
      check("return", 33'(c), 33'(irq_seq_pkg::RETURN_CYC));
      check("hold", 33'(core_hold), 33'h0);
      mark = done_total;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      #(20 * 20000);
      error_cnt++;
      results();
   end
   // Main sequence
   initial begin
      c = $urandom(47);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(irq_seq_pkg::ADDR_STATUS, 33'h0);
      rd(irq_seq_pkg::ADDR_SP, 33'h0);
      rd(8'h1c, 33'h1_0000_0000);
      check("rst_vec", 33'(reset_vector), 33'(irq_seq_pkg::APP_BASE));
      fuse <= 1'b1;
      repeat (2) @(posedge pclk);
      check("rst_vec", 33'(reset_vector), 33'(irq_seq_pkg::BOOT_BASE));
      // Latched flags, priority, hardware and write-one clears, return
      ev = 8'($urandom()) | 8'h06;
      wr(irq_seq_pkg::ADDR_SP, 32'(SP0));
      wr(irq_seq_pkg::ADDR_ENABLE, 32'h06);
      pulse(ev);
      rd(irq_seq_pkg::ADDR_FLAGS, 33'(ev));
      wr(irq_seq_pkg::ADDR_STATUS, 32'h80);
      rd(irq_seq_pkg::ADDR_STATUS, 33'h80);
      exp_q.push_back(vec(irq_seq_pkg::APP_BASE, 1));
      run <= 1'b1;
      entry();
      wr(irq_seq_pkg::ADDR_FLAGS, 32'h0);
      rd(irq_seq_pkg::ADDR_FLAGS, 33'(ev & 8'hfd));
      wr(irq_seq_pkg::ADDR_FLAGS, 32'hfb);
      rd(irq_seq_pkg::ADDR_FLAGS, 33'h04);
      exp_q.push_back(vec(irq_seq_pkg::APP_BASE, 2));
      leave();
      entry();
      check("after_ret", 33'(dn), 33'h1);
      leave();
      // Application lock suppression, then relocated table
      wr(irq_seq_pkg::ADDR_GICTRL, 32'h1);
      app_lock <= 1'b1;
      wr(irq_seq_pkg::ADDR_ENABLE, 32'h80);
      p0 = push_total;
      pulse(8'h80);
      repeat (20) @(posedge pclk);
      check("locked", 33'(push_total - p0), 33'h0);
      exp_q.push_back(vec(irq_seq_pkg::BOOT_BASE, 7));
      app_lock <= 1'b0;
      boot_lock <= 1'b1;
      entry();
      leave();
      // Disable instruction beside a pending request, then enable
      wr(irq_seq_pkg::ADDR_GICTRL, 32'h0);
      wr(irq_seq_pkg::ADDR_ENABLE, 32'h21);
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      p0 = push_total;
      pulse(8'h21);
      run <= 1'b1;
      do_op(2'h2);
      repeat (10) @(posedge pclk);
      check("cli", 33'(push_total - p0), 33'h0);
      check("cli_gie", 33'(gie), 33'h0);
      exp_q.push_back(vec(irq_seq_pkg::APP_BASE, 0));
      do_op(2'h1);
      mark = done_total;
      entry();
      check("after_sei", 33'(dn), 33'h2);
      exp_q.push_back(vec(irq_seq_pkg::APP_BASE, 5));
      leave();
      entry();
      leave();
      // Level source that vanishes before enabling, then persists
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      wr(irq_seq_pkg::ADDR_LEVEL, 32'h08);
      wr(irq_seq_pkg::ADDR_ENABLE, 32'h08);
      wr(irq_seq_pkg::ADDR_STATUS, 32'h0);
      src_cond <= 8'h08;
      repeat (3) @(posedge pclk);
      src_cond <= 8'h00;
      p0 = push_total;
      wr(irq_seq_pkg::ADDR_STATUS, 32'h80);
      run <= 1'b1;
      repeat (10) @(posedge pclk);
      check("level", 33'(push_total - p0), 33'h0);
      exp_q.push_back(vec(irq_seq_pkg::APP_BASE, 3));
      src_cond <= 8'h08;
      entry();
      src_cond <= 8'h00;
      leave();
      // Wake from sleep
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      wr(irq_seq_pkg::ADDR_ENABLE, 32'h10);
      sleeping   <= 1'b1;
      wake_ready <= 1'b1;
      exp_q.push_back(vec(irq_seq_pkg::APP_BASE, 4));
      pulse(8'h10);
      entry();
      check("wake", 33'(cp), 33'(32'(irq_seq_pkg::WAKE_CYC) + 2));
      sleeping   <= 1'b0;
      wake_ready <= 1'b0;
      run        <= 1'b1;
      leave();
      check("queue", 33'(exp_q.size()), 33'h0);
      results();
   end
endmodule
`default_nettype wire
